// ==== hgt_trig_ctl.sv ====
// trigger control: hot-swap sequencer, glitch engine, trigger in/out, apb registers
// assumes apb master per the usual protocol; trigger input is asynchronous 3.3v logic
//
// How it works
// [RL1] in edge mode aimed at hot-swap, each rising trigger edge toggles the hot-swap state.
// [RL2] in level mode aimed at hot-swap, the hot-swap state follows every change of the input.
// [RL3] a setting aims the trigger input at the glitch engine instead of the hot-swap logic.
// [RL4] in edge mode aimed at the glitch engine, each rising edge while no glitch runs starts the selected glitch.
// [RL5] in level mode, a rising edge starts the glitch and a falling edge ends it if still on.
// [RL6] the trigger output follows either the hot-swap state or the glitch state.
// [RL7] the trigger output changes whether trigger input or software started the action.
// [RL8] a glitch can cut the selected pins for as little as 50 ns.
// [RL9] each pin has its own switch and can be cut or glitched on its own.
// [RL10] a hot-swap connects pins in a programmed sequence with optional bounce per source.
// [RL11] bit 1 of the control register reads busy during power-up, power-down or glitch.
// [RL12] power-down timing is the mirror image of the power-up delays of each source.
// [RL13] the trigger input is synchronised before edge or level detection.
//
// Register access over APB and the placing of the registers are this design's own decisions.
`timescale 1ns/1ps
`include "hgt_params.svh"
module hgt_trig_ctl #(
    parameter int NPINS = 8,
    parameter int NSRC = 6
) (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic psel_i,
    input wire logic penable_i,
    input wire logic pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] pwdata_i,
    output logic [31:0] prdata_o,
    output logic pready_o,
    output logic pslverr_o,
    input wire logic trig_in_i,
    output logic trig_out_o,
    output logic [NPINS-1:0] pin_en_o,
    output logic irq_o
);
    import hgt_pkg::*;

    localparam logic [15:0] GLEN_MIN = 16'(`HGT_GLITCH_MIN_CYC);
    localparam logic [7:0] TICK_LAST = 8'(`HGT_TICK_CYC - 1);

    typedef struct packed {
        hgt_seq_t seq;
        logic hs;
        logic [17:0] cnt;
        logic [7:0] pre;
        hgt_gl_t gl;
        logic [15:0] gcnt;
        logic trig_d;
        logic en;
        logic tgt;
        logic lvl;
        logic osel;
        logic [15:0] glen;
        logic [NPINS-1:0] gmask;
        logic [NPINS-1:0][3:0] psrc;
        logic [NSRC-1:0][15:0] dly;
        logic [NSRC-1:0][7:0] bnc;
        logic [2:0] ist;
        logic [2:0] imsk;
        logic [NPINS-1:0] pins;
        logic tout;
        logic [31:0] rdata;
    } hgt_state_t;

    hgt_state_t r;
    hgt_state_t next_r;
    logic trig_s;
    logic [NSRC-1:0] sv;
    logic [NPINS-1:0] pin_val;
    logic [15:0] maxd;
    logic [17:0] maxbw;

    hgt_sync u_sync (
        .mclk_i(mclk_i),
        .resetn_i(resetn_i),
        .d_i(trig_in_i),
        .q_o(trig_s)
    );

    // longest delay and bounce window over all sources
    always_comb begin
        maxd = 16'h0000;
        maxbw = 18'h00000;
        for (int k = 0; k < NSRC; k++) begin
            if (r.dly[k] > maxd) begin
                maxd = r.dly[k];
            end
            if ({r.bnc[k], 4'h0} > maxbw) begin
                maxbw = {6'h00, r.bnc[k], 4'h0};
            end
        end
    end

    // per-source timed level; power-down starts mirror the power-up delays
    for (genvar k = 0; k < NSRC; k++) begin : g_src
        logic [17:0] t0;
        logic [17:0] rel;
        logic [17:0] bw;
        always_comb begin
            t0 = r.hs ? {2'b00, r.dly[k]} : {2'b00, maxd - r.dly[k]}; // RL12
            rel = r.cnt - t0;
            bw = {6'h00, r.bnc[k], 4'h0};
            if (r.seq != HGT_SEQ_RUN) begin
                sv[k] = r.hs;
            end else if (r.cnt < t0) begin
                sv[k] = ~r.hs; // RL10
            end else if (rel < bw) begin
                sv[k] = r.hs ^ rel[`HGT_BOUNCE_SH]; // RL10
            end else begin
                sv[k] = r.hs;
            end
        end
    end

    // per-pin source mux and glitch cut
    for (genvar i = 0; i < NPINS; i++) begin : g_pin
        always_comb begin
            case (r.psrc[i])
                4'h0: pin_val[i] = 1'b0;
                4'h1, 4'h2, 4'h3, 4'h4, 4'h5, 4'h6: pin_val[i] = sv[3'(r.psrc[i] - 4'h1)];
                4'h7: pin_val[i] = r.hs;
                4'h8: pin_val[i] = 1'b1;
                default: pin_val[i] = 1'b0;
            endcase
            if (r.gl == HGT_GL_RUN && r.gmask[i]) begin
                pin_val[i] = 1'b0; // RL9
            end
        end
    end

    logic wr;
    logic rd_setup;
    logic busy;
    logic rise;
    logic fall;
    logic hs_req;
    logic hs_new;
    logic gl_start;
    logic gl_stop;
    logic tick;
    logic seq_done;
    logic gl_done;
    logic mapped;
    logic [31:0] rval;
    logic [2:0] ev;
    logic [3:0] aidx;

    always_comb begin
        next_r = r;
        wr = psel_i && penable_i && pwrite_i;
        rd_setup = psel_i && !penable_i && !pwrite_i;
        busy = (r.seq == HGT_SEQ_RUN) || (r.gl == HGT_GL_RUN); // RL11
        aidx = paddr_i[5:2];
        rise = trig_s && !r.trig_d; // RL13
        fall = !trig_s && r.trig_d;
        next_r.trig_d = trig_s;
        tick = (r.pre == TICK_LAST);
        seq_done = 1'b0;
        gl_done = 1'b0;

        // hot-swap requests from the trigger input or software
        hs_req = 1'b0;
        hs_new = r.hs;
        if (r.en && !r.tgt) begin
            if (r.lvl && (trig_s != r.trig_d)) begin
                hs_req = 1'b1; // RL2
                hs_new = trig_s;
            end else if (!r.lvl && rise) begin
                hs_req = 1'b1; // RL1
                hs_new = ~r.hs;
            end
        end
        if (wr && paddr_i == `HGT_CTRL_OFF && pwdata_i[`HGT_CTRL_PLUG]) begin
            hs_req = 1'b1; // RL7
            hs_new = 1'b1;
        end else if (wr && paddr_i == `HGT_CTRL_OFF && pwdata_i[`HGT_CTRL_PULL]) begin
            hs_req = 1'b1;
            hs_new = 1'b0;
        end

        // sequencer; a request mid-sequence restarts it in the new direction
        case (r.seq)
            HGT_SEQ_IDLE: begin
                next_r.cnt = 18'h00000;
                next_r.pre = 8'h00;
            end
            HGT_SEQ_RUN: begin
                next_r.pre = tick ? 8'h00 : r.pre + 8'h01;
                if (tick) begin
                    next_r.cnt = r.cnt + 18'h00001;
                end
                if (r.cnt >= {2'b00, maxd} + maxbw) begin
                    next_r.seq = HGT_SEQ_IDLE; // RL10
                    seq_done = 1'b1;
                end
            end
            default: next_r.seq = HGT_SEQ_IDLE;
        endcase
        if (hs_req && hs_new != r.hs) begin
            next_r.hs = hs_new;
            next_r.seq = HGT_SEQ_RUN;
            next_r.cnt = 18'h00000;
            next_r.pre = 8'h00;
        end

        // glitch engine
        gl_start = (r.en && r.tgt && rise) // RL3 RL4 RL5
            || (wr && paddr_i == `HGT_CTRL_OFF && pwdata_i[`HGT_CTRL_GLITCH]);
        gl_stop = r.en && r.tgt && r.lvl && fall; // RL5
        case (r.gl)
            HGT_GL_IDLE: begin
                if (gl_start) begin
                    next_r.gl = HGT_GL_RUN; // RL4
                    next_r.gcnt = r.glen - 16'h0001;
                end
            end
            HGT_GL_RUN: begin
                if (gl_stop || r.gcnt == 16'h0000) begin
                    next_r.gl = HGT_GL_IDLE; // RL5 RL8
                    gl_done = 1'b1;
                end else begin
                    next_r.gcnt = r.gcnt - 16'h0001;
                end
            end
            default: next_r.gl = HGT_GL_IDLE;
        endcase

        next_r.pins = pin_val; // RL9
        next_r.tout = r.osel ? (r.gl == HGT_GL_RUN) : r.hs; // RL6 RL7

        // register writes
        if (wr && paddr_i[1:0] == 2'b00) begin
            case (paddr_i)
                `HGT_TRIG_OFF: begin
                    next_r.en = pwdata_i[`HGT_TRIG_EN];
                    next_r.tgt = pwdata_i[`HGT_TRIG_TGT]; // RL3
                    next_r.lvl = pwdata_i[`HGT_TRIG_LVL];
                    next_r.osel = pwdata_i[`HGT_TRIG_OSEL]; // RL6
                end
                // shorter lengths are raised to the 50 ns floor
                `HGT_GLEN_OFF: next_r.glen = (pwdata_i[15:0] < GLEN_MIN) ? GLEN_MIN
                    : pwdata_i[15:0]; // RL8
                `HGT_GMASK_OFF: next_r.gmask = pwdata_i[NPINS-1:0];
                `HGT_IMASK_OFF: next_r.imsk = pwdata_i[2:0];
                default: begin
                    // pin words start at index 8 of the low 64-byte page
                    if (paddr_i >= `HGT_PSRC_BASE && 4'(aidx - 4'h8) < 4'(NPINS)
                        && paddr_i[11:6] == 6'h00) begin
                        next_r.psrc[aidx - 4'h8] = pwdata_i[3:0];
                    end
                    if (paddr_i >= `HGT_SCFG_BASE && 4'(aidx - 4'h8) < 4'(NSRC)
                        && paddr_i[11:6] == 6'h01) begin
                        next_r.dly[aidx - 4'h8] = pwdata_i[15:0];
                        next_r.bnc[aidx - 4'h8] = pwdata_i[23:16];
                    end
                end
            endcase
        end

        // sticky events; a new event wins over a write-one clear
        ev = {r.en && rise, gl_done, seq_done};
        next_r.ist = r.ist & ~((wr && paddr_i == `HGT_ISTAT_OFF) ? pwdata_i[2:0] : 3'h0);
        next_r.ist = next_r.ist | ev;

        // read decode, registered at the setup cycle
        mapped = 1'b1;
        rval = 32'h00000000;
        case (paddr_i)
            `HGT_CTRL_OFF: begin
                rval[`HGT_CTRL_BUSY] = busy; // RL11
                rval[`HGT_CTRL_HS] = r.hs;
                rval[`HGT_CTRL_GON] = (r.gl == HGT_GL_RUN);
            end
            `HGT_TRIG_OFF: rval[3:0] = {r.osel, r.lvl, r.tgt, r.en};
            `HGT_GLEN_OFF: rval[15:0] = r.glen;
            `HGT_GMASK_OFF: rval[NPINS-1:0] = r.gmask;
            `HGT_ISTAT_OFF: rval[2:0] = r.ist;
            `HGT_IMASK_OFF: rval[2:0] = r.imsk;
            `HGT_PINS_OFF: rval[NPINS-1:0] = r.pins;
            default: begin
                mapped = 1'b0;
                if (paddr_i >= `HGT_PSRC_BASE && 4'(aidx - 4'h8) < 4'(NPINS)
                    && paddr_i[11:6] == 6'h00) begin
                    mapped = 1'b1;
                    rval[3:0] = r.psrc[aidx - 4'h8];
                end
                if (paddr_i >= `HGT_SCFG_BASE && 4'(aidx - 4'h8) < 4'(NSRC)
                    && paddr_i[11:6] == 6'h01) begin
                    mapped = 1'b1;
                    rval[23:0] = {r.bnc[aidx - 4'h8], r.dly[aidx - 4'h8]};
                end
            end
        endcase
        if (paddr_i[1:0] != 2'b00) begin
            mapped = 1'b0;
        end
        if (rd_setup) begin
            next_r.rdata = mapped ? rval : 32'h00000000;
        end
    end

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            r <= '0;
            r.seq <= HGT_SEQ_IDLE;
            r.gl <= HGT_GL_IDLE;
            r.glen <= GLEN_MIN;
            r.psrc <= {NPINS{`HGT_PSRC_RST}};
        end else begin
            r <= next_r;
        end
    end

    assign prdata_o = r.rdata;
    assign pready_o = 1'b1;
    assign pslverr_o = psel_i && penable_i && !mapped;
    assign trig_out_o = r.tout;
    assign pin_en_o = r.pins;
    assign irq_o = |(r.ist & r.imsk);

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!resetn_i);

    sequence s_gl_trig_start;
        r.en && r.tgt && rise && r.gl == HGT_GL_IDLE;
    endsequence
    sequence s_gl_held;
        (r.gl == HGT_GL_RUN) [*2];
    endsequence

    edge_toggle_a: assert property ( // RL1
        (r.en && !r.tgt && !r.lvl && rise && !wr) |=> r.hs != $past(r.hs))
        else $error("edge trigger did not toggle hot-swap state");
    level_track_a: assert property ( // RL2
        (r.en && !r.tgt && r.lvl && trig_s != r.trig_d && !wr) |=> r.hs == $past(trig_s))
        else $error("hot-swap state does not follow trigger level");
    glitch_start_a: assert property ( // RL4
        s_gl_trig_start |=> r.gl == HGT_GL_RUN)
        else $error("rising trigger did not start glitch");
    glitch_end_a: assert property ( // RL5
        (r.gl == HGT_GL_RUN && r.en && r.tgt && r.lvl && fall) |=> r.gl == HGT_GL_IDLE)
        else $error("falling trigger did not end glitch");
    glitch_min_a: assert property ( // RL8
        (s_gl_trig_start and (r.glen >= GLEN_MIN) and (!r.lvl)) |=> s_gl_held)
        else $error("glitch shorter than minimum length");
    trig_out_a: assert property ( // RL6
        ##1 trig_out_o == ($past(r.osel) ? $past(r.gl == HGT_GL_RUN) : $past(r.hs)))
        else $error("trigger output follows wrong action");
    sw_glitch_out_a: assert property ( // RL7
        (r.osel && r.gl == HGT_GL_IDLE && wr && paddr_i == `HGT_CTRL_OFF
            && pwdata_i[`HGT_CTRL_GLITCH]) |=> ##1 trig_out_o)
        else $error("software glitch not shown on trigger output");
    pin_cut_a: assert property ( // RL9
        ##1 (pin_en_o & $past(r.gmask & {NPINS{r.gl == HGT_GL_RUN}})) == '0)
        else $error("glitched pin still connected");
    busy_read_a: assert property ( // RL11
        (rd_setup && paddr_i == `HGT_CTRL_OFF && r.seq == HGT_SEQ_RUN)
            |=> prdata_o[`HGT_CTRL_BUSY])
        else $error("busy bit clear during sequence");
    seq_done_a: assert property ( // RL10
        (r.seq == HGT_SEQ_RUN && r.cnt >= {2'b00, maxd} + maxbw) |-> sv == {NSRC{r.hs}})
        else $error("sources unsettled after sequence window");
endmodule // hgt_trig_ctl

// ==== hgt_params.svh ====
// offsets, field positions, reset values and timing counts of the trigger control block
// assumes 32-bit apb data, one aligned word per register
`ifndef HGT_PARAMS_SVH
`define HGT_PARAMS_SVH
`define HGT_CTRL_OFF 12'h000
`define HGT_TRIG_OFF 12'h004
`define HGT_GLEN_OFF 12'h008
`define HGT_GMASK_OFF 12'h00c
`define HGT_ISTAT_OFF 12'h010
`define HGT_IMASK_OFF 12'h014
`define HGT_PINS_OFF 12'h018
`define HGT_PSRC_BASE 12'h020
`define HGT_SCFG_BASE 12'h060
`define HGT_CTRL_PLUG 0
`define HGT_CTRL_BUSY 1
`define HGT_CTRL_PULL 2
`define HGT_CTRL_GLITCH 3
`define HGT_CTRL_HS 4
`define HGT_CTRL_GON 5
`define HGT_TRIG_EN 0
`define HGT_TRIG_TGT 1
`define HGT_TRIG_LVL 2
`define HGT_TRIG_OSEL 3
`define HGT_INT_SEQ 0
`define HGT_INT_GLITCH 1
`define HGT_INT_TRIG 2
`define HGT_PSRC_RST 4'h7
`define HGT_CLK_NS 25
`define HGT_GLITCH_MIN_NS 50
`define HGT_GLITCH_MIN_CYC ((`HGT_GLITCH_MIN_NS + `HGT_CLK_NS - 1) / `HGT_CLK_NS)
`define HGT_TICK_NS 1000
`define HGT_TICK_CYC (`HGT_TICK_NS / `HGT_CLK_NS)
`define HGT_BOUNCE_SH 4
`endif

// ==== hgt_pkg.sv ====
// types shared by the trigger control block
// assumes hgt_params.svh holds all numbers
package hgt_pkg;
    typedef enum logic [1:0] {
        HGT_SEQ_IDLE = 2'b01,
        HGT_SEQ_RUN = 2'b10
    } hgt_seq_t;
    typedef enum logic [1:0] {
        HGT_GL_IDLE = 2'b01,
        HGT_GL_RUN = 2'b10
    } hgt_gl_t;
endpackage

// ==== hgt_sync.sv ====
// two-flop synchroniser for the trigger input
// assumes the input may change at any time relative to mclk_i
`timescale 1ns/1ps
module hgt_sync (
    input wire logic mclk_i,
    input wire logic resetn_i,
    input wire logic d_i,
    output logic q_o
);
    logic meta;
    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            meta <= 1'b0;
            q_o <= 1'b0;
        end else begin
            meta <= d_i; // RL13
            q_o <= meta;
        end
    end

    sync_delay_a: assert property (@(posedge mclk_i) disable iff (!resetn_i) // RL13
        ##2 q_o == $past(d_i, 2)) else $error("synchroniser output not two cycles behind");
endmodule // hgt_sync

// ==== hgt_trig_equip.sv ====
// model of the external test equipment on the two trigger connectors
// assumes the bench calls set_level after a rising edge of mclk_i
`timescale 1ns/1ps
module hgt_trig_equip (
    input wire logic mclk_i,
    input wire logic trig_out_i,
    output logic trig_o
);
    int rise_cnt;
    logic last_out;
    // idle low; the connector has no pull, the equipment always drives it
    initial begin
        trig_o = 1'b0;
        rise_cnt = 0;
        last_out = 1'b0;
    end
    task automatic set_level(input logic v);
        @(posedge mclk_i);
        trig_o <= v;
    endtask
    // counts actions seen on trigger out, as a scope would
    always @(posedge mclk_i) begin
        if (trig_out_i === 1'b1 && last_out === 1'b0) begin
            rise_cnt++;
        end
        last_out <= trig_out_i;
    end
endmodule // hgt_trig_equip

// ==== hgt_trig_ctl_tb.sv ====
// self-checking bench for the trigger control block
// assumes hgt_params.svh offsets and a 40 mhz clock
`timescale 1ns/1ps
`include "hgt_params.svh"
`define CHK(nm, e, g) begin check_count++; if ((g) !== (e)) begin error_cnt++; \
    $display("Error %s expected %h seen %h", nm, e, g); end end
module hgt_trig_ctl_tb;
    import hgt_pkg::*;
    logic mclk_i, resetn_i, psel_i, penable_i, pwrite_i;
    logic [11:0] paddr_i;
    logic [31:0] pwdata_i, prdata_o;
    logic pready_o, pslverr_o, trig_in_i, trig_out_o, irq_o;
    logic [7:0] pin_en_o;
    int error_cnt = 0;
    int check_count = 0;
    logic [31:0] q;
    logic e;
    int dur;
    logic [7:0] pm;
    hgt_trig_ctl hgt_trig_ctl_i (.mclk_i(mclk_i), .resetn_i(resetn_i), .psel_i(psel_i),
        .penable_i(penable_i), .pwrite_i(pwrite_i), .paddr_i(paddr_i), .pwdata_i(pwdata_i),
        .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
        .trig_in_i(trig_in_i), .trig_out_o(trig_out_o), .pin_en_o(pin_en_o), .irq_o(irq_o));
    hgt_trig_equip hgt_trig_equip_i (.mclk_i(mclk_i), .trig_out_i(trig_out_o),
        .trig_o(trig_in_i));
    initial begin
        mclk_i = 1'b0;
        forever #12.5 mclk_i = ~mclk_i;
    end
    task automatic results();
        if (error_cnt == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        @(posedge mclk_i);
        psel_i <= 1'b1;
        penable_i <= 1'b0;
        pwrite_i <= w;
        paddr_i <= a;
        pwdata_i <= d;
        @(posedge mclk_i);
        penable_i <= 1'b1;
        do @(posedge mclk_i); while (pready_o !== 1'b1);
        q = prdata_o;
        e = pslverr_o;
        psel_i <= 1'b0;
        penable_i <= 1'b0;
    endtask
    task automatic wr(input logic [11:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdc(input string nm, input logic [11:0] a, input logic [31:0] x);
        apb(1'b0, a, 32'h0);
        `CHK(nm, x, q)
    endtask
    // s < 8 picks a pin switch, 8 picks trigger out
    function automatic logic sig(input int s);
        return (s < 8) ? pin_en_o[s] : trig_out_o;
    endfunction
    task automatic wait_sig(input int s, input logic v, input int lim);
        int n;
        n = 0;
        do begin
            @(posedge mclk_i);
            #1;
            n++;
        end while (sig(s) !== v && n < lim);
        `CHK("wait", v, sig(s))
    endtask
    task automatic cnt_high();
        dur = 1;
        pm = 8'h00;
        forever begin
            @(posedge mclk_i);
            #1;
            if (dur == 2) pm = pin_en_o;
            if (trig_out_o !== 1'b1 || dur > 200) break;
            dur++;
        end
    endtask
    initial begin
        #(25ns * 20000);
        error_cnt++;
        results();
    end
    initial begin
        resetn_i = 1'b0;
        psel_i = 1'b0;
        penable_i = 1'b0;
        pwrite_i = 1'b0;
        paddr_i = 12'h000;
        pwdata_i = 32'h0;
        repeat (16) @(posedge mclk_i);
        resetn_i <= 1'b1;
        rdc("ctrl", `HGT_CTRL_OFF, 32'h0);
        rdc("glen", `HGT_GLEN_OFF, 32'h2);
        rdc("psrc", `HGT_PSRC_BASE, {28'h0, `HGT_PSRC_RST});
        rdc("unmapped", 12'h0fc, 32'h0);
        `CHK("slverr", 1'b1, e)
        // software plug, trigger out follows hot-swap state
        wr(`HGT_CTRL_OFF, 32'h1);
        wait_sig(8, 1'b1, 50);
        wait_sig(7, 1'b1, 50);
        rdc("pins", `HGT_PINS_OFF, 32'hff);
        // edge mode on hot-swap, with trigger interrupt
        wr(`HGT_ISTAT_OFF, 32'h7);
        wr(`HGT_IMASK_OFF, 32'h4);
        wr(`HGT_TRIG_OFF, 32'h1);
        hgt_trig_equip_i.set_level(1'b1);
        wait_sig(8, 1'b0, 50);
        `CHK("irq", 1'b1, irq_o)
        wr(`HGT_ISTAT_OFF, 32'h4);
        #1;
        `CHK("irq", 1'b0, irq_o)
        hgt_trig_equip_i.set_level(1'b0);
        repeat (8) @(posedge mclk_i);
        `CHK("edge fall", 1'b0, trig_out_o)
        // level mode on hot-swap
        wr(`HGT_TRIG_OFF, 32'h5);
        hgt_trig_equip_i.set_level(1'b1);
        wait_sig(8, 1'b1, 50);
        hgt_trig_equip_i.set_level(1'b0);
        wait_sig(8, 1'b0, 50);
        hgt_trig_equip_i.set_level(1'b1);
        wait_sig(8, 1'b1, 50);
        wait_sig(7, 1'b1, 50);
        // glitch engine in edge mode, out follows glitch
        wr(`HGT_TRIG_OFF, 32'hb);
        hgt_trig_equip_i.set_level(1'b0);
        wr(`HGT_GMASK_OFF, 32'h0f);
        wr(`HGT_GLEN_OFF, 32'h4);
        hgt_trig_equip_i.set_level(1'b1);
        wait_sig(8, 1'b1, 50);
        cnt_high();
        `CHK("glitch len", 4, dur)
        `CHK("glitch pins", 8'hf0, pm)
        rdc("ctrl hs", `HGT_CTRL_OFF, 32'h10);
        // level mode, falling edge ends a long glitch
        wr(`HGT_TRIG_OFF, 32'hf);
        wr(`HGT_GLEN_OFF, 32'd100);
        hgt_trig_equip_i.set_level(1'b0);
        repeat (6) @(posedge mclk_i);
        hgt_trig_equip_i.set_level(1'b1);
        wait_sig(8, 1'b1, 50);
        hgt_trig_equip_i.set_level(1'b0);
        cnt_high();
        `CHK("early end", 1'b1, dur < 10)
        // software glitch with clamped length, trigger input off
        wr(`HGT_TRIG_OFF, 32'h8);
        wr(`HGT_GLEN_OFF, 32'h1);
        rdc("glen", `HGT_GLEN_OFF, 32'h2);
        wr(`HGT_CTRL_OFF, 32'h8);
        wait_sig(8, 1'b1, 50);
        cnt_high();
        `CHK("min glitch", 2, dur)
        // timed sources: pull mirrors plug
        wr(`HGT_TRIG_OFF, 32'h0);
        wr(`HGT_PSRC_BASE, 32'h1);
        wr(`HGT_PSRC_BASE + 12'h4, 32'h2);
        wr(`HGT_SCFG_BASE, 32'h2);
        wr(`HGT_SCFG_BASE + 12'h4, 32'h0);
        wr(`HGT_CTRL_OFF, 32'h4);
        wait_sig(0, 1'b0, 300);
        `CHK("pull order", 1'b1, pin_en_o[1])
        rdc("busy", `HGT_CTRL_OFF, 32'h2);
        wait_sig(1, 1'b0, 300);
        repeat (4) @(posedge mclk_i);
        rdc("idle", `HGT_CTRL_OFF, 32'h0);
        wr(`HGT_CTRL_OFF, 32'h1);
        wait_sig(1, 1'b1, 300);
        `CHK("plug order", 1'b0, pin_en_o[0])
        wait_sig(0, 1'b1, 300);
        `CHK("out count", 1'b1, hgt_trig_equip_i.rise_cnt > 5)
        // bounce field with upper data bits set, then a refused write high up
        wr(`HGT_SCFG_BASE + 12'h4, 32'hff02_0003);
        rdc("scfg", `HGT_SCFG_BASE + 12'h4, 32'h0002_0003);
        wr(12'h800, 32'hffff_ffff);
        `CHK("wr slverr", 1'b1, e)
        rdc("ctrl kept", `HGT_CTRL_OFF, 32'h10);
        // reset in mid-run brings back the defaults
        @(posedge mclk_i);
        resetn_i <= 1'b0;
        repeat (4) @(posedge mclk_i);
        resetn_i <= 1'b1;
        `CHK("rst out", 1'b0, trig_out_o)
        rdc("rst psrc", `HGT_PSRC_BASE, {28'h0, `HGT_PSRC_RST});
        rdc("rst ctrl", `HGT_CTRL_OFF, 32'h0);
        results();
    end
endmodule // hgt_trig_ctl_tb
